// ===== psm_pkg.sv
package psm_pkg;
    localparam int PIN_W = 32;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_PIN = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_UNBLK = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_VALUE = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_CMD = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_STAT = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ST = 4'h6;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 4'h7;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_ABORT = 4'h9;
    localparam logic [1:0] FAIL_LIMIT = 2'h3;
    localparam logic [7:0] QUAL_USE = 8'h08;
    localparam logic [7:0] QUAL_RST = 8'h00;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
    localparam int CTRL_ALLOW = 0;
    localparam int CTRL_ALT_EN = 1;
    localparam int IRQ_OK = 0;
    localparam int IRQ_FAIL = 1;
    localparam int IRQ_BLOCK = 2;
    localparam int IRQ_W = 3;

    typedef enum logic [2:0] {
        PSM_CMD_NONE = 3'h0,
        PSM_CMD_DIS = 3'h1,
        PSM_CMD_DIS_REPL = 3'h2,
        PSM_CMD_ENA = 3'h3,
        PSM_CMD_UNBLK = 3'h4,
        PSM_CMD_VERIFY = 3'h5
    } psm_cmd_t;

    typedef enum logic [1:0] {
        PSM_IDLE = 2'b00,
        PSM_EXEC = 2'b01,
        PSM_DONE = 2'b11
    } psm_fsm_t;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [31:0]       writedata;
    } psm_avs_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } psm_avs_rsp_t;

    typedef struct packed {
        psm_fsm_t          fsm;
        psm_cmd_t          cmd;
        logic              allow;
        logic              alt_en;
        logic [PIN_W-1:0]  pin;
        logic [PIN_W-1:0]  unblk;
        logic [PIN_W-1:0]  value;
        logic              pin_en;
        logic              pin_blk;
        logic              unblk_blk;
        logic [1:0]        pin_fails;
        logic [1:0]        unblk_fails;
        logic [7:0]        alt_qual;
        logic              access;
        logic              last_ok;
        logic              done;
        logic [IRQ_W-1:0]  irq_st;
        logic [IRQ_W-1:0]  irq_en;
        logic              ack;
        logic [31:0]       rdata;
    } psm_state_t;
endpackage

// ===== psm_pin_status_manager.sv
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
module psm_pin_status_manager (
    // clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_nrst,
    // avalon-mm slave
    input  wire psm_pkg::psm_avs_req_t i_avs,
    output      psm_pkg::psm_avs_rsp_t o_avs,
    // status
    output      logic                  o_irq,
    output      logic                  o_access,
    output      logic                  o_pin_blocked
);
    import psm_pkg::*;

    psm_state_t s_q;
    psm_state_t s_d;
    logic       req;
    logic       match_pin;
    logic       match_unb;
    logic       ok;
    logic       fail;
    logic       touched;

    assign req = i_avs.read | i_avs.write;
    assign match_pin = (s_q.value == s_q.pin);
    assign match_unb = (s_q.value == s_q.unblk);

    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.done = 1'b0;
        ok = 1'b0;
        fail = 1'b0;
        touched = 1'b0;
        case (s_q.fsm)
            PSM_IDLE: begin
                if (s_q.cmd != PSM_CMD_NONE) begin
                    s_d.fsm = PSM_EXEC;
                end
            end
            PSM_EXEC: begin
                s_d.fsm = PSM_DONE;
                case (s_q.cmd)
                    PSM_CMD_DIS, PSM_CMD_DIS_REPL: begin
                        if (!s_q.allow || !s_q.pin_en || s_q.pin_blk) begin
                            fail = 1'b0;
                            s_d.last_ok = 1'b0;
                        end else if (s_q.cmd == PSM_CMD_DIS_REPL && !s_q.alt_en) begin
                            s_d.last_ok = 1'b0;
                        end else begin
                            touched = 1'b1;
                            if (match_pin) begin
                                ok = 1'b1;
                                s_d.pin_en = 1'b0;
                                if (s_q.cmd == PSM_CMD_DIS_REPL) begin
                                    s_d.alt_qual = QUAL_USE;
                                end
                            end else begin
                                fail = 1'b1;
                            end
                        end
                    end
                    PSM_CMD_ENA: begin
                        if (!s_q.allow || s_q.pin_en || s_q.pin_blk) begin
                            s_d.last_ok = 1'b0;
                        end else begin
                            touched = 1'b1;
                            if (match_pin) begin
                                ok = 1'b1;
                                s_d.pin_en = 1'b1;
                            end else begin
                                fail = 1'b1;
                            end
                        end
                    end
                    PSM_CMD_VERIFY: begin
                        if (s_q.pin_blk) begin
                            s_d.last_ok = !s_q.pin_en;
                        end else if (!s_q.pin_en) begin
                            s_d.last_ok = 1'b1;
                            s_d.access = 1'b1;
                        end else begin
                            touched = 1'b1;
                            ok = match_pin;
                            fail = !match_pin;
                        end
                    end
                    PSM_CMD_UNBLK: begin
                        // runs regardless of pin block state
                        if (s_q.unblk_blk) begin
                            s_d.last_ok = 1'b0;
                            s_d.irq_st[IRQ_FAIL] = 1'b1;
                        end else if (match_unb) begin
                            s_d.pin_blk = 1'b0;
                            s_d.pin_fails = 2'h0;
                            s_d.unblk_fails = 2'h0;
                            s_d.last_ok = 1'b1;
                            s_d.access = 1'b1;
                            s_d.irq_st[IRQ_OK] = 1'b1;
                        end else begin
                            s_d.last_ok = 1'b0;
                            s_d.irq_st[IRQ_FAIL] = 1'b1;
                            if (s_q.unblk_fails == FAIL_LIMIT - 2'h1) begin
                                s_d.unblk_blk = 1'b1;
                            end else begin
                                s_d.unblk_fails = s_q.unblk_fails + 2'h1;
                            end
                        end
                    end
                    default: s_d.last_ok = 1'b0;
                endcase
                if (touched && ok) begin
                    s_d.last_ok = 1'b1;
                    s_d.pin_fails = 2'h0;
                    s_d.access = 1'b1;
                    s_d.irq_st[IRQ_OK] = 1'b1;
                end
                if (touched && fail) begin
                    s_d.last_ok = 1'b0;
                    s_d.irq_st[IRQ_FAIL] = 1'b1;
                    if (s_q.pin_fails == FAIL_LIMIT - 2'h1) begin
                        s_d.pin_blk = 1'b1;
                        s_d.irq_st[IRQ_BLOCK] = 1'b1;
                        if (s_q.pin_en) begin
                            s_d.access = 1'b0;
                        end
                    end else begin
                        s_d.pin_fails = s_q.pin_fails + 2'h1;
                    end
                end
                // procedures that end without a compare still report their outcome
                if (!touched && s_q.cmd != PSM_CMD_UNBLK) begin
                    if (s_d.last_ok) begin
                        s_d.irq_st[IRQ_OK] = 1'b1;
                    end else begin
                        s_d.irq_st[IRQ_FAIL] = 1'b1;
                    end
                end
            end
            PSM_DONE: begin
                s_d.fsm = PSM_IDLE;
                s_d.cmd = PSM_CMD_NONE;
                s_d.done = 1'b1;
            end
            default: s_d.fsm = PSM_IDLE;
        endcase

        // bus: one wait cycle per access so read data come from a flop
        if (req && !s_q.ack) begin
            s_d.ack = 1'b1;
            s_d.rdata = RD_UNMAPPED;
            if (i_avs.read) begin
                case (i_avs.address)
                    OFF_CTRL: s_d.rdata = {30'h0, s_q.alt_en, s_q.allow};
                    OFF_PIN: s_d.rdata = RD_UNMAPPED; // secret values never read back
                    OFF_CMD: s_d.rdata = {29'h0, s_q.cmd};
                    // busy covers a command that is latched but not yet started
                    OFF_STAT: s_d.rdata = {14'h0, s_q.alt_qual, s_q.unblk_fails,
                        s_q.pin_fails, s_q.last_ok, s_q.access, s_q.unblk_blk,
                        s_q.pin_blk, s_q.pin_en,
                        (s_q.fsm != PSM_IDLE || s_q.cmd != PSM_CMD_NONE)};
                    OFF_IRQ_ST: s_d.rdata = {29'h0, s_q.irq_st};
                    OFF_IRQ_EN: s_d.rdata = {29'h0, s_q.irq_en};
                    default: s_d.rdata = RD_UNMAPPED;
                endcase
            end else begin
                case (i_avs.address)
                    OFF_CTRL: begin
                        s_d.allow = i_avs.writedata[CTRL_ALLOW];
                        s_d.alt_en = i_avs.writedata[CTRL_ALT_EN];
                    end
                    OFF_PIN: s_d.pin = i_avs.writedata[PIN_W-1:0];
                    OFF_UNBLK: s_d.unblk = i_avs.writedata[PIN_W-1:0];
                    OFF_VALUE: s_d.value = i_avs.writedata[PIN_W-1:0];
                    OFF_CMD: begin
                        if (s_q.fsm == PSM_IDLE && s_q.cmd == PSM_CMD_NONE) begin
                            s_d.cmd = psm_cmd_t'(i_avs.writedata[2:0]);
                        end
                    end
                    OFF_IRQ_CLR: begin
                        // set wins over clear for bits not already set: new events on them are ored back below
                        s_d.irq_st = (s_q.irq_st & ~i_avs.writedata[IRQ_W-1:0])
                            | (s_d.irq_st & ~s_q.irq_st);
                    end
                    OFF_IRQ_EN: s_d.irq_en = i_avs.writedata[IRQ_W-1:0];
                    OFF_ABORT: begin
                        // abort drops a pending procedure before it executes
                        if (s_q.fsm != PSM_EXEC) begin
                            s_d.cmd = PSM_CMD_NONE;
                            s_d.fsm = PSM_IDLE;
                            s_d.access = 1'b0;
                            s_d.last_ok = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            s_q <= '0;
            s_q.allow <= 1'b1;
            s_q.pin_en <= 1'b1;
            s_q.alt_en <= 1'b1;
            s_q.alt_qual <= QUAL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_avs.waitrequest = req & ~s_q.ack;
    assign o_avs.readdata = s_q.rdata;
    assign o_irq = |(s_q.irq_st & s_q.irq_en);
    assign o_access = s_q.access;
    assign o_pin_blocked = s_q.pin_blk;

    a_block_third: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.fsm == PSM_EXEC && touched && fail && s_q.pin_fails == 2'h2)
        |=> s_q.pin_blk) else $error("pin not blocked on third failure");
    a_block_access: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.fsm == PSM_EXEC && touched && fail && s_q.pin_fails == 2'h2 && s_q.pin_en)
        |=> !o_access) else $error("access kept after block");
    a_disable_ok: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.fsm == PSM_EXEC && s_q.cmd == PSM_CMD_DIS && s_q.allow && s_q.pin_en
        && !s_q.pin_blk && match_pin) |=> !s_q.pin_en && s_q.last_ok)
        else $error("disable did not take");
    a_disable_refused: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.fsm == PSM_EXEC && s_q.cmd == PSM_CMD_DIS && (!s_q.pin_en || s_q.pin_blk))
        |=> $stable(s_q.pin_en) && !s_q.last_ok) else $error("refused disable changed state");
    a_repl_qual: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.fsm == PSM_EXEC && s_q.cmd == PSM_CMD_DIS_REPL && s_q.allow && s_q.alt_en
        && s_q.pin_en && !s_q.pin_blk && match_pin) |=> s_q.alt_qual == 8'h08)
        else $error("qualifier not set");
    a_mismatch_keep: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.fsm == PSM_EXEC && s_q.cmd != PSM_CMD_UNBLK && touched && !match_pin)
        |=> $stable(s_q.pin_en) && !s_q.last_ok) else $error("mismatch changed enable");
    a_enable_refused: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.fsm == PSM_EXEC && s_q.cmd == PSM_CMD_ENA && (s_q.pin_en || s_q.pin_blk))
        |=> $stable(s_q.pin_en) && !s_q.last_ok) else $error("refused enable changed state");
    a_enable_ok: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.fsm == PSM_EXEC && s_q.cmd == PSM_CMD_ENA && s_q.allow && !s_q.pin_en
        && !s_q.pin_blk && match_pin) |=> s_q.pin_en && o_access)
        else $error("enable did not take");
    a_unblock_ok: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.fsm == PSM_EXEC && s_q.cmd == PSM_CMD_UNBLK && !s_q.unblk_blk && match_unb)
        |=> !s_q.pin_blk && s_q.pin_fails == 2'h0 && s_q.last_ok)
        else $error("unblock did not clear");
    a_unblock_lock: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.fsm == PSM_EXEC && s_q.cmd == PSM_CMD_UNBLK && s_q.unblk_blk)
        |=> $stable(s_q.pin_blk) && !s_q.last_ok) else $error("blocked unblock acted");

    // a latched command walks exec, done, idle with no stall
    sequence s_cmd_walk;
        (s_q.fsm == PSM_EXEC)
        ##1 (s_q.fsm == PSM_DONE)
        ##1 (s_q.fsm == PSM_IDLE && s_q.done);
    endsequence

    sequence s_bus_accept;
        req && o_avs.waitrequest;
    endsequence

    sequence s_abort_wr;
        req && i_avs.write && i_avs.address == OFF_ABORT;
    endsequence

    property p_cmd_walk;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.fsm == PSM_IDLE && s_q.cmd != PSM_CMD_NONE && !(req && i_avs.write
        && i_avs.address == OFF_ABORT)) |=> s_cmd_walk;
    endproperty
    a_cmd_walk: assert property (p_cmd_walk) else $error("command did not complete");

    property p_bus_answer;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        s_bus_accept |=> s_q.ack ##1 !s_q.ack;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");

    a_forbid_ena: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.fsm == PSM_EXEC && s_q.cmd == PSM_CMD_ENA && !s_q.allow)
        |=> $stable(s_q.pin_en) && !s_q.last_ok) else $error("forbidden enable acted");
    a_forbid_dis: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.fsm == PSM_EXEC && (s_q.cmd == PSM_CMD_DIS || s_q.cmd == PSM_CMD_DIS_REPL)
        && !s_q.allow) |=> $stable(s_q.pin_en) && !s_q.last_ok)
        else $error("forbidden disable acted");
    a_repl_noalt: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.fsm == PSM_EXEC && s_q.cmd == PSM_CMD_DIS_REPL && !s_q.alt_en)
        |=> $stable(s_q.alt_qual) && $stable(s_q.pin_en))
        else $error("replace without alt key acted");
    a_unblock_free: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.fsm == PSM_EXEC && s_q.cmd == PSM_CMD_UNBLK && !s_q.pin_blk
        && !s_q.unblk_blk && match_unb) |=> s_q.last_ok)
        else $error("unblock refused on free pin");
    a_ok_access: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.fsm == PSM_EXEC && touched && ok) |=> o_access)
        else $error("success gave no access");

    // an abort outside execution always leaves the session without access
    property p_abort_access;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (s_abort_wr and s_bus_accept) ##0 (s_q.fsm != PSM_EXEC) |=> !o_access;
    endproperty
    a_abort_access: assert property (p_abort_access) else $error("abort kept access");

    a_irq_clear: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (req && i_avs.write && !s_q.ack && i_avs.address == OFF_IRQ_CLR
        && i_avs.writedata[IRQ_W-1:0] == 3'h7 && s_q.fsm != PSM_EXEC)
        |=> s_q.irq_st == 3'h0) else $error("status clear ignored");
    a_irq_level: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (s_q.irq_st == 3'h0) |-> !o_irq) else $error("interrupt without status");
endmodule // psm_pin_status_manager

// ===== psm_terminal.sv
`timescale 1ns/10ps
// terminal side: one register access at a time, never read and write together
module psm_terminal (
    // clock
    input  wire logic                  i_clk_sys,
    // avalon-mm master
    output      psm_pkg::psm_avs_req_t o_avs,
    input  wire psm_pkg::psm_avs_rsp_t i_avs
);
    import psm_pkg::*;

    initial o_avs = '0;

    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge i_clk_sys);
        o_avs.address <= a;
        o_avs.write <= w;
        o_avs.read <= ~w;
        o_avs.writedata <= d;
        do @(posedge i_clk_sys); while (i_avs.waitrequest !== 1'b0);
        q = i_avs.readdata;
        o_avs.read <= 1'b0;
        o_avs.write <= 1'b0;
        // stale data must not look valid once released
        o_avs.writedata <= ~d;
    endtask
endmodule // psm_terminal

// ===== psm_pin_status_manager_bench.sv
`timescale 1ns/10ps
module psm_pin_status_manager_bench;
    import psm_pkg::*;
    localparam logic [31:0] PIN = 32'h0000_1234;
    localparam logic [31:0] PUK = 32'h0000_5678;
    localparam logic [31:0] BAD = 32'h0000_0BAD;
    logic         i_clk_sys;
    logic         i_nrst;
    psm_avs_req_t avs_req;
    psm_avs_rsp_t avs_rsp;
    logic         irq;
    logic         access;
    logic         pin_blocked;
    logic [31:0]  st;
    logic [31:0]  q;
    int           num_errors;
    int           check_count;
    int           cycles;

    psm_pin_status_manager psm_pin_status_manager_inst (
        .i_clk_sys     (i_clk_sys),
        .i_nrst        (i_nrst),
        .i_avs         (avs_req),
        .o_avs         (avs_rsp),
        .o_irq         (irq),
        .o_access      (access),
        .o_pin_blocked (pin_blocked)
    );
    psm_terminal psm_terminal_inst (
        .i_clk_sys (i_clk_sys),
        .o_avs     (avs_req),
        .i_avs     (avs_rsp)
    );

    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end

    // the whole sequence needs well under 2000 cycles
    always @(posedge i_clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        psm_terminal_inst.xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        psm_terminal_inst.xfer(1'b0, a, 32'h0000_0000, q);
    endtask

    task automatic run(input psm_cmd_t c, input logic [31:0] v);
        wr(OFF_VALUE, v);
        wr(OFF_CMD, 32'(c));
        do rd(OFF_STAT); while (q[0] !== 1'b0);
        st = q;
    endtask

    // last_ok, pin enabled, pin blocked
    task automatic flags(input string n, input logic ok, input logic en, input logic blk);
        chk(n, 32'({ok, en, blk}), 32'({st[5], st[1], st[2]}));
    endtask

    task automatic t_reset();
        rd(OFF_STAT);
        chk("reset_stat", 32'h0000_0002, q);
        chk("reset_outs", 32'h0000_0000, 32'({access, pin_blocked, irq}));
        rd(4'hF);
        chk("unmapped", RD_UNMAPPED, q);
        wr(OFF_PIN, PIN);
        wr(OFF_UNBLK, PUK);
        wr(OFF_IRQ_EN, 32'h0000_0007);
    endtask

    task automatic t_block();
        for (int i = 0; i < 3; i++) begin
            run(PSM_CMD_VERIFY, BAD);
            chk("block_step", 32'(i == 2), 32'(pin_blocked));
        end
        flags("verify_bad", 1'b0, 1'b1, 1'b1);
        run(PSM_CMD_DIS, PIN);
        flags("dis_blocked", 1'b0, 1'b1, 1'b1);
        run(PSM_CMD_ENA, PIN);
        flags("ena_blocked", 1'b0, 1'b1, 1'b1);
    endtask

    task automatic t_unblock();
        run(PSM_CMD_UNBLK, BAD);
        flags("unblk_bad", 1'b0, 1'b1, 1'b1);
        run(PSM_CMD_UNBLK, PUK);
        flags("unblk_ok", 1'b1, 1'b1, 1'b0);
        chk("fails_clr", 32'h0, 32'(st[7:6]));
        run(PSM_CMD_VERIFY, BAD);
        run(PSM_CMD_UNBLK, PUK);
        flags("unblk_free", 1'b1, 1'b1, 1'b0);
        chk("fails_clr2", 32'h0, 32'(st[7:6]));
    endtask

    task automatic t_endis();
        run(PSM_CMD_DIS, PIN);
        flags("dis_ok", 1'b1, 1'b0, 1'b0);
        chk("access", 32'h1, 32'(access));
        run(PSM_CMD_DIS, PIN);
        flags("dis_again", 1'b0, 1'b0, 1'b0);
        run(PSM_CMD_ENA, BAD);
        flags("ena_bad", 1'b0, 1'b0, 1'b0);
        run(PSM_CMD_ENA, PIN);
        flags("ena_ok", 1'b1, 1'b1, 1'b0);
        run(PSM_CMD_DIS_REPL, BAD);
        flags("repl_bad", 1'b0, 1'b1, 1'b0);
        chk("qual_kept", 32'(QUAL_RST), 32'(st[17:10]));
        wr(OFF_CTRL, 32'h0000_0001);
        run(PSM_CMD_DIS_REPL, PIN);
        flags("repl_noalt", 1'b0, 1'b1, 1'b0);
        wr(OFF_CTRL, 32'h0000_0003);
        run(PSM_CMD_DIS_REPL, PIN);
        flags("repl_ok", 1'b1, 1'b0, 1'b0);
        chk("qual_use", 32'(QUAL_USE), 32'(st[17:10]));
    endtask

    task automatic t_abort_allow();
        wr(OFF_ABORT, 32'h0000_0001);
        rd(OFF_STAT);
        chk("abort_access", 32'h0, 32'({q[4], access}));
        wr(OFF_CTRL, 32'h0000_0002);
        run(PSM_CMD_ENA, PIN);
        flags("ena_forbid", 1'b0, 1'b0, 1'b0);
        wr(OFF_CTRL, 32'h0000_0003);
        run(PSM_CMD_ENA, PIN);
        flags("ena_allow", 1'b1, 1'b1, 1'b0);
        chk("ena_access", 32'h1, 32'(access));
    endtask

    task automatic t_puk_block();
        repeat (3) run(PSM_CMD_UNBLK, BAD);
        chk("puk_blocked", 32'h1, 32'(st[3]));
        run(PSM_CMD_UNBLK, PUK);
        flags("unblk_dead", 1'b0, 1'b1, 1'b0);
    endtask

    task automatic t_irq();
        rd(OFF_IRQ_ST);
        chk("irq_st", 32'h0000_0007, q);
        chk("irq_on", 32'h1, 32'(irq));
        wr(OFF_IRQ_CLR, 32'h0000_0007);
        rd(OFF_IRQ_ST);
        chk("irq_clr", 32'h0000_0000, q);
        chk("irq_off", 32'h0, 32'(irq));
        wr(OFF_IRQ_EN, 32'h0000_0000);
        run(PSM_CMD_VERIFY, BAD);
        rd(OFF_IRQ_ST);
        chk("irq_fail", 32'h0000_0002, q);
        chk("irq_masked", 32'h0, 32'(irq));
        wr(OFF_IRQ_EN, 32'h0000_0002);
        rd(OFF_IRQ_EN);
        chk("irq_unmask", 32'h1, 32'(irq));
    endtask

    initial begin
        i_nrst = 1'b0;
        repeat (16) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        t_reset();
        t_block();
        t_unblock();
        t_endis();
        t_abort_allow();
        t_puk_block();
        t_irq();
        summarize();
    end
endmodule // psm_pin_status_manager_bench
